// >>> src/pcr_pkg.sv
// Package: constants and carriers for the coding-sublayer to fabric datapath block
package pcr_pkg;
    // ******************************************************************
    // Widths
    // ******************************************************************
    localparam int unsigned HALF_W     = 40;          // One transfer half
    localparam int unsigned FULL_W     = 80;          // Whole parallel word
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned NBYTES     = 10;
    localparam int unsigned MIN_DR_W   = 10;          // Double rate needs width above this
    // ******************************************************************
    // Sideband chains
    // ******************************************************************
    localparam int unsigned SB_W       = 8;           // Sideband bits per chain
    localparam int unsigned FAST_LEN   = 10;          // Fast chain minimum cycles
    localparam int unsigned SLOW_LEN   = 120;         // Slow chain minimum cycles
    localparam int unsigned CNT_W      = 7;
    localparam logic [CNT_W-1:0] FAST_LAST = 7'h09;
    localparam logic [CNT_W-1:0] SLOW_LAST = 7'h77;
    // ******************************************************************
    // Wishbone register map (byte addresses)
    // ******************************************************************
    localparam logic [3:0]  ADDR_CTRL  = 4'h0;
    localparam logic [3:0]  ADDR_STAT  = 4'h4;
    localparam logic [3:0]  ADDR_SBOUT = 4'h8;
    localparam logic [3:0]  ADDR_SBIN  = 4'hC;
    localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
    // Control fields
    localparam int unsigned C_DR       = 0;           // Double rate on
    localparam int unsigned C_TXBIT    = 1;           // Transmit bit reversal
    localparam int unsigned C_TXBYTE   = 2;           // Transmit byte reversal
    localparam int unsigned C_ENH      = 3;           // Enhanced path selected
    localparam int unsigned C_INVMK    = 4;           // Inverted receive marking
    localparam int unsigned C_ALIGN    = 5;           // Alignment mode, 2 bits
    localparam int unsigned C_WIDTH    = 8;           // Fifo width, 7 bits
    // ******************************************************************
    // Types
    // ******************************************************************
    typedef enum logic [1:0] {
        PCR_AL_BITSLIP = 2'b00,
        PCR_AL_MANUAL  = 2'b01,
        PCR_AL_SYNCSM  = 2'b10
    } pcr_align_t;
    typedef struct packed {
        logic [HALF_W-1:0] data;
        logic              mark;
    } pcr_half_t;
    typedef enum logic [1:0] {
        PCR_CH_LOAD  = 2'b00,
        PCR_CH_SHIFT = 2'b01
    } pcr_chain_t;
endpackage : pcr_pkg

// >>> src/pcr_core.sv
// Datapath options block: reversal, double rate halves, sideband chains
// Function
// - Transmit bit reversal static, applies to all channels
// - Receive bit order input reverses delivered word bits
// - Receive bit reversal works in every alignment mode
// - Receive reversals absent on enhanced path
// - Transmit byte reversal static, applies to all channels
// - Receive byte order input reverses delivered bytes
// - Transmit coding FIFO outputs double width words
// - Transmit fabric FIFO keeps equal widths, same clock
// - Receive coding FIFO accepts double width words
// - Receive fabric FIFO keeps equal widths, same clock
// - Double rate splits word, barred at width ten
// - Marking bit only in double rate, two halves
// - Enhanced 32 and direct widths invert receive marking
// - Sideband crosses via fast and slow chains
`timescale 1ns/100ps
module pcr_core
    import pcr_pkg::*;
#(
    parameter bit TX_BIT_REV  = 1'b0,
    parameter bit TX_BYTE_REV = 1'b0
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [3:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    // Transmit, fabric side
    input  wire pcr_pkg::pcr_half_t      tx_half_i,
    input  wire logic                    tx_valid_i,
    // Transmit, coding side
    output logic      [pcr_pkg::FULL_W-1:0] tx_word_o,
    output logic                         tx_word_valid_o,
    // Receive, coding side
    input  wire logic [pcr_pkg::FULL_W-1:0] rx_word_i,
    input  wire logic                    rx_word_valid_i,
    // Receive, fabric side
    input  wire logic                    rx_bitrev_i,
    input  wire logic                    rx_byterev_i,
    output pcr_pkg::pcr_half_t           rx_half_o,
    output logic                         rx_valid_o,
    // Sideband
    input  wire logic [pcr_pkg::SB_W-1:0] sb_fast_i,
    input  wire logic [pcr_pkg::SB_W-1:0] sb_slow_i,
    output logic      [pcr_pkg::SB_W-1:0] sb_fast_o,
    output logic      [pcr_pkg::SB_W-1:0] sb_slow_o
);
    import pcr_pkg::*;

    // ******************************************************************
    // Reversal functions
    // ******************************************************************
    // Mirror whole word, msb to lsb
    function automatic logic [FULL_W-1:0] bit_rev(input logic [FULL_W-1:0] w);
        logic [FULL_W-1:0] r;
        for (int i = 0; i < FULL_W; i++) begin
            r[i] = w[FULL_W-1-i];
        end
        return r;
    endfunction : bit_rev

    // Exchange byte positions end for end
    function automatic logic [FULL_W-1:0] byte_rev(input logic [FULL_W-1:0] w);
        logic [FULL_W-1:0] r;
        for (int i = 0; i < NBYTES; i++) begin
            r[i*BYTE_W +: BYTE_W] = w[(NBYTES-1-i)*BYTE_W +: BYTE_W];
        end
        return r;
    endfunction : byte_rev

    // ******************************************************************
    // Register file
    // ******************************************************************
    logic [31:0] ctrl_reg, ctrl_next;
    logic        ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic        dr_ok;
    logic [1:0]  sb_busy;
    logic        wb_req;

    // Double rate only legal above ten bits
    assign dr_ok  = ctrl_reg[C_DR] && (ctrl_reg[C_WIDTH +: 7] > 7'(MIN_DR_W));
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;

    // Decode and answer, one wait state
    always_comb begin
        ctrl_next = ctrl_reg;
        rdat_next = 32'h0000_0000;
        ack_next  = wb_req;
        if (wb_req && wb_we_i && wb_adr_i == ADDR_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    ctrl_next[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
        end
        if (wb_req && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_CTRL:  rdat_next = ctrl_reg;
                ADDR_STAT:  rdat_next = {28'h000_0000, sb_busy, TX_BYTE_REV, dr_ok};
                ADDR_SBOUT: rdat_next = {16'h0000, sb_slow_o, sb_fast_o};
                ADDR_SBIN:  rdat_next = {16'h0000, sb_slow_i, sb_fast_i};
                default:    rdat_next = 32'h0000_0000;  // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= CTRL_RST;
            ack_reg  <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            ack_reg  <= ack_next;
            rdat_reg <= rdat_next;
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

    // ******************************************************************
    // Transmit path: fabric halves into coding-side double width word
    // ******************************************************************
    // Fabric-side stage keeps width; the pair register doubles it. The
    // faster half rate is modelled as one half per clock.
    logic [HALF_W-1:0] tx_lo_reg, tx_lo_next;
    logic [FULL_W-1:0] tx_word_reg, tx_word_next;
    logic              tx_v_reg, tx_v_next;
    logic [FULL_W-1:0] tx_raw;

    always_comb begin
        tx_lo_next   = tx_lo_reg;
        tx_word_next = tx_word_reg;
        tx_v_next    = 1'b0;
        tx_raw       = {tx_half_i.data, tx_lo_reg};
        if (tx_valid_i) begin
            if (!dr_ok) begin
                // Single rate: half is the word, no marking used
                tx_raw       = {{(FULL_W-HALF_W){1'b0}}, tx_half_i.data};
                tx_v_next    = 1'b1;
            end else if (!tx_half_i.mark) begin
                tx_lo_next   = tx_half_i.data;   // Lower half, mark 0
            end else begin
                tx_v_next    = 1'b1;             // Upper half completes
            end
            // Static options, same for every channel
            if (tx_v_next) begin
                tx_word_next = TX_BIT_REV  ? bit_rev(tx_raw) : tx_raw;
                tx_word_next = TX_BYTE_REV ? byte_rev(tx_word_next) : tx_word_next;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_lo_reg   <= '0;
            tx_word_reg <= '0;
            tx_v_reg    <= 1'b0;
        end else begin
            tx_lo_reg   <= tx_lo_next;
            tx_word_reg <= tx_word_next;
            tx_v_reg    <= tx_v_next;
        end
    end
    assign tx_word_o       = tx_word_reg;
    assign tx_word_valid_o = tx_v_reg;

    // ******************************************************************
    // Receive path: reversal, then split into halves
    // ******************************************************************
    // Reversal sits in the aligner stage whatever the alignment mode,
    // so the mode field does not gate it.
    logic [FULL_W-1:0] rx_keep_reg, rx_keep_next;
    logic              rx_pend_reg, rx_pend_next;
    pcr_half_t         rx_half_reg, rx_half_next;
    logic              rx_v_reg, rx_v_next;
    logic [FULL_W-1:0] rx_al;
    logic              inv_mk;

    // Inverted marking for enhanced 32 and direct widths
    assign inv_mk = ctrl_reg[C_INVMK];

    always_comb begin
        rx_keep_next = rx_keep_reg;
        rx_pend_next = 1'b0;
        rx_half_next = rx_half_reg;
        rx_v_next    = 1'b0;
        rx_al        = rx_word_i;
        // Standard path only; enhanced ignores the order inputs
        if (!ctrl_reg[C_ENH]) begin
            if (rx_bitrev_i) begin
                rx_al = bit_rev(rx_al);
            end
            if (rx_byterev_i) begin
                rx_al = byte_rev(rx_al);
            end
        end
        if (rx_pend_reg) begin
            // Second half of a double width word
            rx_half_next.data = rx_keep_reg[FULL_W-1:HALF_W];
            rx_half_next.mark = !inv_mk;
            rx_v_next         = 1'b1;
        end else if (rx_word_valid_i) begin
            rx_half_next.data = rx_al[HALF_W-1:0];
            rx_half_next.mark = dr_ok ? inv_mk : 1'b0;
            rx_v_next         = 1'b1;
            rx_keep_next      = rx_al;
            rx_pend_next      = dr_ok;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_keep_reg <= '0;
            rx_pend_reg <= 1'b0;
            rx_half_reg <= '0;
            rx_v_reg    <= 1'b0;
        end else begin
            rx_keep_reg <= rx_keep_next;
            rx_pend_reg <= rx_pend_next;
            rx_half_reg <= rx_half_next;
            rx_v_reg    <= rx_v_next;
        end
    end
    assign rx_half_o  = rx_half_reg;
    assign rx_valid_o = rx_v_reg;

    // ******************************************************************
    // Sideband chains
    // ******************************************************************
    // Capture, shift for the chain length, then update the output.
    // Inputs changing mid-shift are missed until the next capture.
    logic [SB_W-1:0]  ch_cap_reg  [2];
    logic [SB_W-1:0]  ch_cap_next [2];
    logic [SB_W-1:0]  ch_out_reg  [2];
    logic [SB_W-1:0]  ch_out_next [2];
    logic [CNT_W-1:0] ch_cnt_reg  [2];
    logic [CNT_W-1:0] ch_cnt_next [2];
    pcr_chain_t       ch_st_reg   [2];
    pcr_chain_t       ch_st_next  [2];
    logic [SB_W-1:0]  ch_in       [2];
    logic [CNT_W-1:0] ch_last     [2];

    assign ch_in[0]   = sb_fast_i;
    assign ch_in[1]   = sb_slow_i;
    assign ch_last[0] = FAST_LAST;
    assign ch_last[1] = SLOW_LAST;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            ch_cap_next[c] = ch_cap_reg[c];
            ch_out_next[c] = ch_out_reg[c];
            ch_cnt_next[c] = ch_cnt_reg[c];
            ch_st_next[c]  = ch_st_reg[c];
            unique case (ch_st_reg[c])
                PCR_CH_LOAD: begin
                    ch_cap_next[c] = ch_in[c];
                    ch_cnt_next[c] = '0;
                    ch_st_next[c]  = PCR_CH_SHIFT;
                end
                PCR_CH_SHIFT: begin
                    if (ch_cnt_reg[c] == ch_last[c]) begin
                        ch_out_next[c] = ch_cap_reg[c];
                        ch_st_next[c]  = PCR_CH_LOAD;
                    end else begin
                        ch_cnt_next[c] = ch_cnt_reg[c] + 7'h01;
                    end
                end
                default: ch_st_next[c] = PCR_CH_LOAD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        for (int c = 0; c < 2; c++) begin
            if (rst_i) begin
                ch_cap_reg[c] <= '0;
                ch_out_reg[c] <= '0;
                ch_cnt_reg[c] <= '0;
                ch_st_reg[c]  <= PCR_CH_LOAD;
            end else begin
                ch_cap_reg[c] <= ch_cap_next[c];
                ch_out_reg[c] <= ch_out_next[c];
                ch_cnt_reg[c] <= ch_cnt_next[c];
                ch_st_reg[c]  <= ch_st_next[c];
            end
        end
    end
    assign sb_fast_o = ch_out_reg[0];
    assign sb_slow_o = ch_out_reg[1];
    assign sb_busy   = {ch_st_reg[1] == PCR_CH_SHIFT, ch_st_reg[0] == PCR_CH_SHIFT};

    // ******************************************************************
    // Assertions
    // ******************************************************************
    property p_rx_second_half;
        @(posedge clk_i) disable iff (rst_i)
        (rx_word_valid_i && dr_ok && !rx_pend_reg) |=> ##1 (rx_valid_o && rx_half_o.mark == !inv_mk);
    endproperty
    a_rx_second_half: assert property (p_rx_second_half) else $error("second half missing");

    property p_single_no_mark;
        @(posedge clk_i) disable iff (rst_i)
        (rx_word_valid_i && !dr_ok && !rx_pend_reg) |=> (rx_valid_o && !rx_half_o.mark);
    endproperty
    a_single_no_mark: assert property (p_single_no_mark) else $error("mark set in single rate");

    property p_narrow_no_dr;
        @(posedge clk_i) disable iff (rst_i)
        (ctrl_reg[C_WIDTH +: 7] <= 7'(MIN_DR_W)) |-> !dr_ok;
    endproperty
    a_narrow_no_dr: assert property (p_narrow_no_dr) else $error("double rate at narrow width");

    // Mirrored upper input half, built apart from the datapath function
    logic [HALF_W-1:0] rx_up_mirror;
    always_comb begin
        for (int i = 0; i < HALF_W; i++) begin
            rx_up_mirror[i] = rx_word_i[FULL_W-1-i];
        end
    end

    property p_bitrev;
        @(posedge clk_i) disable iff (rst_i)
        (rx_word_valid_i && !rx_pend_reg && rx_bitrev_i && !rx_byterev_i && !ctrl_reg[C_ENH])
        |=> rx_half_o.data == $past(rx_up_mirror);
    endproperty
    a_bitrev: assert property (p_bitrev) else $error("bit reversal wrong");

    property p_enh_plain;
        @(posedge clk_i) disable iff (rst_i)
        (rx_word_valid_i && !rx_pend_reg && ctrl_reg[C_ENH])
        |=> rx_half_o.data == $past(rx_word_i[HALF_W-1:0]);
    endproperty
    a_enh_plain: assert property (p_enh_plain) else $error("reversal on enhanced path");

    property p_tx_pair;
        @(posedge clk_i) disable iff (rst_i)
        (tx_valid_i && dr_ok && tx_half_i.mark) |=> tx_word_valid_o;
    endproperty
    a_tx_pair: assert property (p_tx_pair) else $error("upper half did not emit word");

    property p_fast_update;
        @(posedge clk_i) disable iff (rst_i)
        (ch_st_reg[0] == PCR_CH_LOAD) |=> (ch_st_reg[0] == PCR_CH_SHIFT && ch_cnt_reg[0] == 7'h00)
        ##9 (ch_st_reg[0] == PCR_CH_SHIFT && ch_cnt_reg[0] == FAST_LAST) ##1 ch_st_reg[0] == PCR_CH_LOAD;
    endproperty
    a_fast_update: assert property (p_fast_update) else $error("fast chain length wrong");

    property p_wb_ack;
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !ack_reg) |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_wb_ack: assert property (p_wb_ack) else $error("wishbone ack timing wrong");
endmodule : pcr_core

// >>> verif/pcr_fabric_model.sv
// Fabric-side partner: sends marked transmit halves and rebuilds received words
`timescale 1ns/100ps
module pcr_fabric_model
    import pcr_pkg::*;
(
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // Transmit halves toward the block
    output pcr_pkg::pcr_half_t          tx_half_o,
    output logic                        tx_valid_o,
    // Received halves from the block
    input  wire pcr_pkg::pcr_half_t     rx_half_i,
    input  wire logic                   rx_valid_i,
    input  wire logic                   upper_mark_i,
    output logic [pcr_pkg::FULL_W-1:0]  word_o,
    output logic [pcr_pkg::HALF_W-1:0]  last_data_o,
    output int                          half_cnt_o
);
    import pcr_pkg::*;
    // ****************************************************************
    // Transmit side
    // ****************************************************************
    initial begin
        tx_half_o  = '0;
        tx_valid_o = 1'b0;
    end
    // Lower half then upper half, held until the taking edge
    task automatic send_pair(input logic [FULL_W-1:0] w);
        @(posedge clk_i);
        tx_half_o  <= {w[HALF_W-1:0], 1'b0};
        tx_valid_o <= 1'b1;
        @(posedge clk_i);
        tx_half_o  <= {w[FULL_W-1:HALF_W], 1'b1};
        @(posedge clk_i);
        tx_valid_o <= 1'b0;
        tx_half_o  <= ~tx_half_o;                   // Released lines show no stale value
    endtask : send_pair
    // Single rate: one half, marking bit unused
    task automatic send_single(input logic [HALF_W-1:0] d);
        @(posedge clk_i);
        tx_half_o  <= {d, 1'b0};
        tx_valid_o <= 1'b1;
        @(posedge clk_i);
        tx_valid_o <= 1'b0;
        tx_half_o  <= ~tx_half_o;
    endtask : send_single
    // ****************************************************************
    // Receive side
    // ****************************************************************
    // Placement by marking bit only, so arrival order does not matter
    always @(posedge clk_i) begin
        if (rst_i) begin
            word_o     <= '0;
            half_cnt_o <= 0;
        end else if (rx_valid_i) begin
            half_cnt_o  <= half_cnt_o + 1;
            last_data_o <= rx_half_i.data;
            if (rx_half_i.mark == upper_mark_i) begin
                word_o[FULL_W-1:HALF_W] <= rx_half_i.data;
            end else begin
                word_o[HALF_W-1:0] <= rx_half_i.data;
            end
        end
    end
endmodule : pcr_fabric_model

// >>> verif/pcr_core_tb_top.sv
// Self-checking bench for the reversal and double rate datapath block
`timescale 1ns/100ps
module pcr_core_tb_top;
    import pcr_pkg::*;
    // ****************************************************************
    // Signals
    // ****************************************************************
    logic               clk_i;
    logic               rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rx_vld = 1'b0;
    logic               bitr = 1'b0, byter = 1'b0, upmark = 1'b1, tx_wvld, rx_hvld, tx_hvld;
    logic [3:0]         adr = 4'h0, sel = 4'h0;
    logic [31:0]        wdat = 32'h0, rdat, rd, c;
    logic [FULL_W-1:0]  rx_word = '0, tx_word, tx_word_b, fab_word, w;
    pcr_half_t          tx_half, rx_half;
    logic [SB_W-1:0]    sbf_i = 8'h00, sbs_i = 8'h00, sbf_o, sbs_o;
    logic [HALF_W-1:0]  last_data;
    int                 half_cnt, n0, k, cycles = 0, bad_count = 0, num_checks = 0;
    integer             seed = 32'hBCD2260B;
    // One clock carries both halves; the doubled clock is the fabric's to supply
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    pcr_core #(.TX_BIT_REV(1'b1), .TX_BYTE_REV(1'b0)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .tx_half_i(tx_half), .tx_valid_i(tx_hvld), .tx_word_o(tx_word), .tx_word_valid_o(tx_wvld),
        .rx_word_i(rx_word), .rx_word_valid_i(rx_vld), .rx_bitrev_i(bitr), .rx_byterev_i(byter),
        .rx_half_o(rx_half), .rx_valid_o(rx_hvld), .sb_fast_i(sbf_i), .sb_slow_i(sbs_i),
        .sb_fast_o(sbf_o), .sb_slow_o(sbs_o));
    // Second build with byte reversal only, fed from the same lines
    pcr_core #(.TX_BIT_REV(1'b0), .TX_BYTE_REV(1'b1)) dut_byte (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
        .tx_half_i(tx_half), .tx_valid_i(tx_hvld), .tx_word_o(tx_word_b), .tx_word_valid_o(),
        .rx_word_i(rx_word), .rx_word_valid_i(rx_vld), .rx_bitrev_i(bitr), .rx_byterev_i(byter),
        .rx_half_o(), .rx_valid_o(), .sb_fast_i(sbf_i), .sb_slow_i(sbs_i),
        .sb_fast_o(), .sb_slow_o());
    pcr_fabric_model fab (
        .clk_i(clk_i), .rst_i(rst_i), .tx_half_o(tx_half), .tx_valid_o(tx_hvld),
        .rx_half_i(rx_half), .rx_valid_i(rx_hvld), .upper_mark_i(upmark), .word_o(fab_word),
        .last_data_o(last_data), .half_cnt_o(half_cnt));
    // ****************************************************************
    // Expectations and checking
    // ****************************************************************
    function automatic logic [FULL_W-1:0] bit_rev(input logic [FULL_W-1:0] x);
        for (int i = 0; i < FULL_W; i++) bit_rev[i] = x[FULL_W-1-i];
    endfunction : bit_rev
    function automatic logic [FULL_W-1:0] byte_rev(input logic [FULL_W-1:0] x);
        for (int b = 0; b < NBYTES; b++) byte_rev[b*BYTE_W+:BYTE_W] = x[(NBYTES-1-b)*BYTE_W+:BYTE_W];
    endfunction : byte_rev
    // Standard path reverses bits first, then bytes; enhanced path passes through
    function automatic logic [FULL_W-1:0] rx_exp(input logic [FULL_W-1:0] x, input logic bi, by, en);
        if (!en && bi) x = bit_rev(x);
        if (!en && by) x = byte_rev(x);
        return x;
    endfunction : rx_exp
    function automatic logic [FULL_W-1:0] rnd80();
        return FULL_W'({$random(seed), $random(seed), $random(seed)});
    endfunction : rnd80
    task automatic check(input string name, input logic [FULL_W-1:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : give_verdict
    // Hang guard: the whole run needs well under two thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            give_verdict();
        end
    end
    // ****************************************************************
    // Bus and stream drivers
    // ****************************************************************
    // Classic cycle: hold until ack is sampled high, then release
    task automatic wb_xfer(input logic w_en, input logic [3:0] a, s, input logic [31:0] d,
                           output logic [31:0] r);
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w_en;
        adr  <= a;
        sel  <= s;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb_xfer
    task automatic tx_check(input logic [FULL_W-1:0] exp, exp_b);
        #1;
        for (int i = 0; i < 6 && tx_wvld !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
        end
        check("tx_word_valid", tx_wvld, 1'b1);
        check("tx_word", tx_word, exp);
        check("tx_word_byte", tx_word_b, exp_b);
    endtask : tx_check
    // One coding-side word, then idle lines carry its inverse
    task automatic rx_send(input logic [FULL_W-1:0] x);
        @(posedge clk_i);
        rx_word <= x;
        rx_vld  <= 1'b1;
        @(posedge clk_i);
        rx_vld  <= 1'b0;
        rx_word <= ~x;
        repeat (3) @(posedge clk_i);
    endtask : rx_send
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wb_xfer(1'b0, ADDR_CTRL, 4'hF, 32'h0, rd);
        check("ctrl_reset", rd, CTRL_RST);
        wb_xfer(1'b0, 4'h2, 4'hF, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        wb_xfer(1'b1, ADDR_STAT, 4'hF, 32'hFFFF_FFFF, rd);
        wb_xfer(1'b1, ADDR_CTRL, 4'hF, 32'h0000_2801, rd);
        wb_xfer(1'b1, ADDR_CTRL, 4'h2, 32'h0000_0000, rd);   // Lane outside sel left alone
        wb_xfer(1'b1, ADDR_CTRL, 4'h1, 32'h0000_FF01, rd);
        wb_xfer(1'b0, ADDR_CTRL, 4'hF, 32'h0, rd);
        check("ctrl_lanes", rd, 32'h0000_0001);
        wb_xfer(1'b1, ADDR_CTRL, 4'hF, 32'h0000_2801, rd);
        wb_xfer(1'b0, ADDR_STAT, 4'hF, 32'h0, rd);
        check("stat_dr", rd[1:0], 2'b01);
        for (k = 0; k < 6; k++) begin
            w = rnd80();
            fab.send_pair(w);
            tx_check(bit_rev(w), byte_rev(w));
        end
        for (k = 0; k < 9; k++) begin
            c = 32'h0000_2801;
            c[C_INVMK] = k[0];
            c[C_ALIGN+:2] = 2'(k % 3);
            c[C_ENH] = k[3];
            wb_xfer(1'b1, ADDR_CTRL, 4'hF, c, rd);
            bitr   <= k[1] | k[3];
            byter  <= k[2] | k[3];
            upmark <= ~c[C_INVMK];
            n0 = half_cnt;
            w = rnd80();
            rx_send(w);
            check("rx_word", fab_word, rx_exp(w, bitr, byter, c[C_ENH]));
            check("rx_halves", FULL_W'(half_cnt - n0), 80'd2);
        end
        // Width ten bars double rate: single halves both ways
        wb_xfer(1'b1, ADDR_CTRL, 4'hF, 32'h0000_0A01, rd);
        wb_xfer(1'b0, ADDR_STAT, 4'hF, 32'h0, rd);
        check("stat_single", rd[0], 1'b0);
        w = rnd80();
        fab.send_single(w[HALF_W-1:0]);
        tx_check(bit_rev({40'h0, w[HALF_W-1:0]}), byte_rev({40'h0, w[HALF_W-1:0]}));
        bitr  <= 1'b0;
        byter <= 1'b0;
        n0 = half_cnt;
        rx_send(w);
        check("rx_single_cnt", FULL_W'(half_cnt - n0), 80'd1);
        check("rx_single", last_data, w[HALF_W-1:0]);
        // Sideband inputs held far beyond both chain periods
        sbf_i <= 8'($random(seed));
        sbs_i <= 8'($random(seed));
        repeat (260) @(posedge clk_i);
        check("sb_fast", sbf_o, sbf_i);
        check("sb_slow", sbs_o, sbs_i);
        wb_xfer(1'b0, ADDR_SBOUT, 4'hF, 32'h0, rd);
        check("sb_out_reg", rd, {16'h0, sbs_i, sbf_i});
        give_verdict();
    end
endmodule : pcr_core_tb_top
